// file: core/ssf_pkg.sv
`default_nettype none
package ssf_pkg;
  // ----------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------
  localparam int             ADR_W    = 4;
  localparam logic [3:0]     ADR_STAT = 4'h0;
  localparam logic [3:0]     ADR_RXD  = 4'h4;
  localparam logic [3:0]     ADR_TXD  = 4'h8;
  localparam logic [3:0]     ADR_CTRL = 4'hC;
  // ----------------------------------------------------------
  // status flags: index into flag vector, bit in status word
  // ----------------------------------------------------------
  localparam int             NFLAG    = 5;
  localparam int             F_TXE    = 0;
  localparam int             F_RXF    = 1;
  localparam int             F_OVR    = 2;
  localparam int             F_FRM    = 3;
  localparam int             F_PAR    = 4;
  localparam int             FLAG_POS [NFLAG] = '{7, 6, 5, 4, 3};
  localparam int             TXEND_BIT = 2;
  localparam logic [4:0]     FLAG_RST = 5'h01;
  localparam logic           TXEND_RST = 1'h1;
  // ----------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------
  localparam int             C_RXEN   = 0;
  localparam int             C_TXEN   = 1;
  localparam int             C_SYNC   = 2;
  localparam int             C_PAREN  = 3;
  localparam int             C_PARODD = 4;
  localparam int             C_STOP2  = 5;
  localparam int             CTRL_W   = 6;
  localparam logic [5:0]     CTRL_RST = 6'h00;
endpackage
`default_nettype wire

// file: core/ssf_flag.sv
`timescale 1ns/100ps
`default_nettype none
// sticky flag, cleared by clr_i, or by a 0 write only after it was read as 1
module ssf_flag #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  input  wire logic rd_i,
  input  wire logic wr0_i,
  output var  logic flag_o,
  output var  logic armed_o
);
  logic clr_any;

  assign clr_any = clr_i | (wr0_i & armed_o);

  // set beats clear so an event in the clear cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= RST_VAL;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_any) begin
      flag_o <= 1'b0;
    end
  end

  // a fresh event needs a fresh read before a 0 write clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_o <= 1'b0;
    end else if (rd_i & flag_o) begin
      armed_o <= 1'b1;
    end else if (~flag_o | clr_any) begin
      armed_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: core/ssf_rx_check.sv
`timescale 1ns/100ps
`default_nettype none
// end-of-character error check, asynchronous mode only
module ssf_rx_check #(
  parameter int DW = 8
) (
  input  wire logic [DW-1:0] data_i,
  input  wire logic          par_bit_i,
  input  wire logic          stop_bit_i,
  input  wire logic          async_i,
  input  wire logic          par_en_i,
  input  wire logic          par_odd_i,
  output wire logic          frm_err_o,
  output wire logic          par_err_o
);
  // only the first stop bit is looked at
  assign frm_err_o = async_i & ~stop_bit_i;
  assign par_err_o = async_i & par_en_i & ((^{data_i, par_bit_i}) != par_odd_i);
endmodule
`default_nettype wire

// file: core/ssf_status.sv
// What this block does
// - Good character moves shift data into holding register and sets receive-full.
// - Receive-full clears by 0 write after read-as-1, or holding register read.
// - Errored character leaves receive-full alone; receiver disabled leaves holding register and receive-full alone.
// - Character ending with receive-full set raises overrun and is discarded.
// - Error flags clear only by 0 write after having been read as 1.
// - Turning the receiver off keeps all error flags unchanged.
// - Overrun stops reception; in synchronous mode also transmission.
// - Asynchronous stop bit sampled at character end; 0 raises framing error.
// - With two stop bits only the first one is checked.
// - Framing error still loads holding register but not receive-full.
// - Framing error stops reception; synchronous mode stops transmission too.
// - Parity enabled, asynchronous: ones count mismatch with odd/even raises parity error.
// - Parity error loads holding register, no receive-full, reception halted.
// - Transmit-end sets when last bit leaves with transmit-empty set, or transmitter off.
// - Transmit-end clears by transmit-empty 0 write after read, or holding write.
// - Transmit-end is read-only.
// - Reset: receive-full and errors 0, transmit-end 1.
// - Writing 1 to a status flag does nothing.
// - Transmit-empty sets on load into shift register or transmitter off.
`timescale 1ns/100ps
`default_nettype none
module ssf_status #(
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // ----------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output var  logic [31:0]   wb_dat_o,
  output var  logic          wb_ack_o,
  // ----------------------------------------------------------
  // receive shifter side
  // ----------------------------------------------------------
  input  wire logic          rx_done_i,
  input  wire logic [DW-1:0] rx_shift_i,
  input  wire logic          rx_par_i,
  input  wire logic          rx_stop_i,
  // ----------------------------------------------------------
  // transmit shifter side
  // ----------------------------------------------------------
  input  wire logic          tx_load_i,
  input  wire logic          tx_last_i,
  output var  logic [DW-1:0] tx_data_o,
  output var  logic          tx_empty_o,
  // ----------------------------------------------------------
  // mode and permission outputs
  // ----------------------------------------------------------
  output var  logic [5:0]    ctrl_o,
  output var  logic          rx_allow_o,
  output var  logic          tx_allow_o
);
  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  logic                      req;
  logic                      wr_lo;
  logic                      wr_stat;
  logic                      rd_stat;
  logic                      rd_rxd;
  logic                      wr_txd;
  logic                      wr_ctrl;
  logic                      tx_off;
  logic [5:0]                ctrl_ff;
  logic [DW-1:0]             rx_hold_ff;
  logic                      tx_end_ff;
  logic [7:0]                stat;
  logic [31:0]               nxt_dat;

  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lo   = req & wb_we_i & wb_sel_i[0];
  assign wr_stat = wr_lo & (wb_adr_i == ssf_pkg::ADR_STAT);
  assign wr_txd  = wr_lo & (wb_adr_i == ssf_pkg::ADR_TXD);
  assign wr_ctrl = wr_lo & (wb_adr_i == ssf_pkg::ADR_CTRL);
  assign rd_stat = req & ~wb_we_i & (wb_adr_i == ssf_pkg::ADR_STAT);
  assign rd_rxd  = req & ~wb_we_i & (wb_adr_i == ssf_pkg::ADR_RXD);
  // transmitter switched from on to off
  assign tx_off  = wr_ctrl & ctrl_ff[ssf_pkg::C_TXEN] & ~wb_dat_i[ssf_pkg::C_TXEN];

  // one wait state: ack one cycle after the request appears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_comb begin
    nxt_dat = 32'h0000_0000;
    case (wb_adr_i)
      ssf_pkg::ADR_STAT: nxt_dat[7:0] = stat;
      ssf_pkg::ADR_RXD:  nxt_dat[DW-1:0] = rx_hold_ff;
      ssf_pkg::ADR_TXD:  nxt_dat[DW-1:0] = tx_data_o;
      ssf_pkg::ADR_CTRL: nxt_dat[5:0] = ctrl_ff;
      default:           nxt_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req & ~wb_we_i) begin
      wb_dat_o <= nxt_dat;
    end
  end

  // ----------------------------------------------------------
  // control and transmit holding registers
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= ssf_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= wb_dat_i[5:0];
    end
  end

  assign ctrl_o = ctrl_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_o <= '0;
    end else if (wr_txd) begin
      tx_data_o <= wb_dat_i[DW-1:0];
    end
  end

  // ----------------------------------------------------------
  // receive side: check and take a character
  // ----------------------------------------------------------
  logic [ssf_pkg::NFLAG-1:0] flag_v;
  logic [ssf_pkg::NFLAG-1:0] armed_v;
  logic [ssf_pkg::NFLAG-1:0] set_v;
  logic [ssf_pkg::NFLAG-1:0] clr_v;
  logic [ssf_pkg::NFLAG-1:0] wr0_v;
  logic                      frm_c;
  logic                      par_c;
  logic                      blocked;
  logic                      rx_take;
  logic                      rx_full;

  ssf_rx_check #(
    .DW         (DW)
  ) u_check (
    .data_i     (rx_shift_i),
    .par_bit_i  (rx_par_i),
    .stop_bit_i (rx_stop_i),
    .async_i    (~ctrl_ff[ssf_pkg::C_SYNC]),
    .par_en_i   (ctrl_ff[ssf_pkg::C_PAREN]),
    .par_odd_i  (ctrl_ff[ssf_pkg::C_PARODD]),
    .frm_err_o  (frm_c),
    .par_err_o  (par_c)
  );

  assign rx_full = flag_v[ssf_pkg::F_RXF];
  // any pending error freezes the receiver
  assign blocked = flag_v[ssf_pkg::F_OVR] | flag_v[ssf_pkg::F_FRM] | flag_v[ssf_pkg::F_PAR];
  assign rx_take = rx_done_i & ctrl_ff[ssf_pkg::C_RXEN] & ~blocked;

  // all receive flag sets come from the same rx_take cycle; transmit-empty sets from tx_load_i or tx_off
  always_comb begin
    set_v              = '0;
    set_v[ssf_pkg::F_TXE] = tx_load_i | tx_off;
    set_v[ssf_pkg::F_RXF] = rx_take & ~rx_full & ~frm_c & ~par_c;
    set_v[ssf_pkg::F_OVR] = rx_take & rx_full;
    set_v[ssf_pkg::F_FRM] = rx_take & ~rx_full & frm_c;
    set_v[ssf_pkg::F_PAR] = rx_take & ~rx_full & par_c;
    clr_v              = '0;
    clr_v[ssf_pkg::F_TXE] = wr_txd;
    clr_v[ssf_pkg::F_RXF] = rd_rxd;
  end

  // overrun discards; framing and parity errors still load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_hold_ff <= '0;
    end else if (rx_take & ~rx_full) begin
      rx_hold_ff <= rx_shift_i;
    end
  end

  // ----------------------------------------------------------
  // status flags
  // ----------------------------------------------------------
  for (genvar i = 0; i < ssf_pkg::NFLAG; i++) begin : g_flag
    // a 1 write leaves the flag alone
    assign wr0_v[i] = wr_stat & ~wb_dat_i[ssf_pkg::FLAG_POS[i]];
    ssf_flag #(
      .RST_VAL (ssf_pkg::FLAG_RST[i])
    ) u_flag (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .set_i   (set_v[i]),
      .clr_i   (clr_v[i]),
      .rd_i    (rd_stat),
      .wr0_i   (wr0_v[i]),
      .flag_o  (flag_v[i]),
      .armed_o (armed_v[i])
    );
  end

  // read-only: bus writes reach it only via the empty flag, a transmit data write or turning the transmitter off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_end_ff <= ssf_pkg::TXEND_RST;
    end else if ((tx_last_i & flag_v[ssf_pkg::F_TXE]) | tx_off) begin
      tx_end_ff <= 1'b1;
    end else if ((wr0_v[ssf_pkg::F_TXE] & armed_v[ssf_pkg::F_TXE]) | wr_txd) begin
      tx_end_ff <= 1'b0;
    end
  end

  always_comb begin
    stat = 8'h00;
    for (int k = 0; k < ssf_pkg::NFLAG; k++) begin
      stat[ssf_pkg::FLAG_POS[k]] = flag_v[k];
    end
    stat[ssf_pkg::TXEND_BIT] = tx_end_ff;
  end

  assign tx_empty_o = flag_v[ssf_pkg::F_TXE];

  // ----------------------------------------------------------
  // permissions to the shifters, one cycle behind the flags
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_allow_o <= 1'b0;
      tx_allow_o <= 1'b0;
    end else begin
      rx_allow_o <= ctrl_ff[ssf_pkg::C_RXEN] & ~blocked;
      tx_allow_o <= ctrl_ff[ssf_pkg::C_TXEN] & ~(ctrl_ff[ssf_pkg::C_SYNC] & blocked);
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_good;
    rx_take && !rx_full && !frm_c && !par_c;
  endsequence

  sequence s_over;
    rx_take && rx_full;
  endsequence

  sequence s_frm;
    rx_take && !rx_full && frm_c;
  endsequence

  sequence s_par;
    rx_take && !rx_full && par_c;
  endsequence

  full_set_a: assert property (s_good |=> rx_full && rx_hold_ff == $past(rx_shift_i))
    else $error("good character not stored");

  full_clr_a: assert property (rd_rxd && !set_v[ssf_pkg::F_RXF] |=> !rx_full)
    else $error("receive-full not cleared by data read");

  rx_hold_a: assert property (rx_done_i && !ctrl_ff[ssf_pkg::C_RXEN]
                              |=> $stable(rx_hold_ff) && !$rose(rx_full))
    else $error("disabled receiver changed holding data");

  ovr_set_a: assert property (s_over |=> flag_v[ssf_pkg::F_OVR] && $stable(rx_hold_ff))
    else $error("overrun not flagged or data overwritten");

  err_clr_a: assert property (flag_v[ssf_pkg::F_OVR] && wr0_v[ssf_pkg::F_OVR]
                              && !armed_v[ssf_pkg::F_OVR] |=> flag_v[ssf_pkg::F_OVR])
    else $error("overrun cleared without prior read");

  rx_block_a: assert property (flag_v[ssf_pkg::F_OVR] && rx_done_i
                               |=> $stable(rx_hold_ff))
    else $error("reception continued during overrun");

  frm_set_a: assert property (s_frm |=> flag_v[ssf_pkg::F_FRM] && !rx_full
                              && rx_hold_ff == $past(rx_shift_i))
    else $error("framing error handling wrong");

  sync_tx_a: assert property (ctrl_ff[ssf_pkg::C_SYNC] && blocked
                              ##1 ctrl_ff[ssf_pkg::C_SYNC] && blocked |-> !tx_allow_o)
    else $error("sync transmit allowed while error pending");

  end_set_a: assert property (tx_off |=> tx_end_ff && tx_empty_o)
    else $error("transmitter off did not set end and empty");

  end_clr_a: assert property (wr_txd && !tx_off && !(tx_last_i && tx_empty_o)
                              |=> !tx_end_ff)
    else $error("transmit-end not cleared by data write");

  rst_val_a: assert property (@(posedge clk_i) disable iff (1'b0)
                              rst_i |=> stat == 8'h84)
    else $error("wrong status after reset");

  par_set_a: assert property (s_par |=> flag_v[ssf_pkg::F_PAR] && !rx_full
                              && rx_hold_ff == $past(rx_shift_i))
    else $error("parity error handling wrong");

  par_halt_a: assert property (flag_v[ssf_pkg::F_PAR] && rx_done_i
                               |=> $stable(rx_hold_ff))
    else $error("reception continued during parity error");

  frm_keep_a: assert property (flag_v[ssf_pkg::F_FRM] && wr0_v[ssf_pkg::F_FRM]
                               && !armed_v[ssf_pkg::F_FRM] |=> flag_v[ssf_pkg::F_FRM])
    else $error("framing error cleared without prior read");

  err_rxoff_a: assert property (wr_ctrl && !wb_dat_i[ssf_pkg::C_RXEN] && !rx_done_i
                                |=> $stable(flag_v[ssf_pkg::F_PAR:ssf_pkg::F_OVR]))
    else $error("receiver off changed an error flag");

  ones_wr_a: assert property (wr_stat && (&wb_dat_i[7:3]) && !(|set_v)
                              |=> $stable(flag_v))
    else $error("writing ones changed a flag");

  end_ro_a: assert property (wr_stat && wb_dat_i[ssf_pkg::FLAG_POS[ssf_pkg::F_TXE]]
                             && !tx_last_i |=> $stable(tx_end_ff))
    else $error("status write changed transmit-end");

  empty_set_a: assert property (tx_load_i |=> tx_empty_o)
    else $error("load did not set transmit-empty");

  end_last_a: assert property (tx_last_i && tx_empty_o |=> tx_end_ff)
    else $error("last bit with empty set did not set transmit-end");

  rx_allow_a: assert property (blocked |=> !rx_allow_o)
    else $error("receiver allowed while error pending");

  wb_ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");
endmodule
`default_nettype wire

// file: bench/ssf_remote.sv
`timescale 1ns/100ps
`default_nettype none
// far side of the serial lines, reduced to character-level events
module ssf_remote #(
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  output var  logic          rx_done_o,
  output var  logic [DW-1:0] rx_shift_o,
  output var  logic          rx_par_o,
  output var  logic          rx_stop_o,
  output var  logic          tx_load_o,
  output var  logic          tx_last_o
);
  initial begin
    rx_done_o  = 1'b0;
    rx_shift_o = '0;
    rx_par_o   = 1'b0;
    rx_stop_o  = 1'b0;
    tx_load_o  = 1'b0;
    tx_last_o  = 1'b0;
  end
  // ----------------------------------------------------------
  // one received character, first stop bit only
  // ----------------------------------------------------------
  task automatic send(input logic [DW-1:0] d, input logic p, input logic s);
    @(posedge clk_i);
    rx_done_o  <= 1'b1;
    rx_shift_o <= d;
    rx_par_o   <= p;
    rx_stop_o  <= s;
    @(posedge clk_i);
    // lines no longer valid: show the inverse so stale data never matches
    rx_done_o  <= 1'b0;
    rx_shift_o <= ~d;
    rx_par_o   <= ~p;
    rx_stop_o  <= ~s;
  endtask
  // ----------------------------------------------------------
  // transmit shifter events
  // ----------------------------------------------------------
  task automatic shift(input logic ld, input logic ls);
    @(posedge clk_i);
    tx_load_o <= ld;
    tx_last_o <= ls;
    @(posedge clk_i);
    tx_load_o <= 1'b0;
    tx_last_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [3:0] A_ST  = ssf_pkg::ADR_STAT;
  localparam logic [3:0] A_RX  = ssf_pkg::ADR_RXD;
  localparam logic [3:0] A_TX  = ssf_pkg::ADR_TXD;
  localparam logic [3:0] A_CT  = ssf_pkg::ADR_CTRL;
  // run needs well under a thousand cycles
  localparam int         LIMIT = 4000;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
  logic        wb_ack_o, rx_done, rx_par, rx_stop, tx_load, tx_last;
  logic        tx_empty_o, rx_allow_o, tx_allow_o, p;
  logic [7:0]  rx_shift, tx_data_o;
  logic [5:0]  ctrl_o;
  int          num_errors = 0, n_tests = 0, cycles = 0;
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  ssf_status #(.DW(8)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_done_i(rx_done), .rx_shift_i(rx_shift), .rx_par_i(rx_par),
    .rx_stop_i(rx_stop), .tx_load_i(tx_load), .tx_last_i(tx_last), .tx_data_o(tx_data_o),
    .tx_empty_o(tx_empty_o), .ctrl_o(ctrl_o), .rx_allow_o(rx_allow_o),
    .tx_allow_o(tx_allow_o));
  ssf_remote #(.DW(8)) u_peer (
    .clk_i(clk_i), .rx_done_o(rx_done), .rx_shift_o(rx_shift), .rx_par_o(rx_par),
    .rx_stop_o(rx_stop), .tx_load_o(tx_load), .tx_last_o(tx_last));
  // ----------------------------------------------------------
  // reporting
  // ----------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------
  // classic wishbone single cycle, entered just after an edge
  // ----------------------------------------------------------
  task automatic wb_io(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    // no cap here: only the run's cycle ceiling ends a hung wait
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb_io(1'b1, a, d);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb_io(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(A_ST, 32'h84, "status_reset");
    rdc(A_CT, 32'h00, "ctrl_reset");
    rdc(4'h2, 32'h00, "unmapped");
    wr(A_CT, 32'h03);
    u_peer.send(8'h5A, 1'b0, 1'b1);
    rdc(A_ST, 32'hC4, "full_set");
    wr(A_ST, 32'hFF);
    rdc(A_ST, 32'hC4, "ones_write");
    rdc(A_RX, 32'h5A, "rx_data");
    rdc(A_ST, 32'h84, "read_clear");
    u_peer.send(8'h66, 1'b0, 1'b1);
    rdc(A_ST, 32'hC4, "full_again");
    wr(A_ST, 32'hBF);
    rdc(A_ST, 32'h84, "zero_clear");
    // receiver off: character must leave no trace
    wr(A_CT, 32'h02);
    u_peer.send(8'h77, 1'b0, 1'b1);
    rdc(A_ST, 32'h84, "rx_off_status");
    rdc(A_RX, 32'h66, "rx_off_data");
    // overrun in synchronous mode
    wr(A_CT, 32'h07);
    u_peer.send(8'h11, 1'b0, 1'b1);
    u_peer.send(8'h22, 1'b0, 1'b1);
    wr(A_ST, 32'hDF);
    rdc(A_ST, 32'hE4, "overrun_set");
    @(negedge clk_i);
    chk("rx_allow_ovr", 32'h0, {31'h0, rx_allow_o});
    chk("tx_allow_ovr", 32'h0, {31'h0, tx_allow_o});
    @(posedge clk_i);
    u_peer.send(8'h33, 1'b0, 1'b1);
    rdc(A_RX, 32'h11, "overrun_keep");
    rdc(A_ST, 32'hA4, "overrun_held");
    wr(A_ST, 32'hDF);
    rdc(A_ST, 32'h84, "overrun_clear");
    @(negedge clk_i);
    chk("tx_allow_back", 32'h1, {31'h0, tx_allow_o});
    @(posedge clk_i);
    // framing error, clear attempt before any read
    wr(A_CT, 32'h03);
    u_peer.send(8'h3C, 1'b0, 1'b0);
    wr(A_ST, 32'hEF);
    rdc(A_ST, 32'h94, "frame_set");
    rdc(A_RX, 32'h3C, "frame_data");
    @(negedge clk_i);
    chk("rx_allow_frm", 32'h0, {31'h0, rx_allow_o});
    @(posedge clk_i);
    u_peer.send(8'h44, 1'b0, 1'b1);
    rdc(A_RX, 32'h3C, "frame_halt");
    wr(A_CT, 32'h02);
    rdc(A_ST, 32'h94, "rx_off_keeps");
    wr(A_CT, 32'h03);
    wr(A_ST, 32'hEF);
    rdc(A_ST, 32'h84, "frame_clear");
    // two stop bits, first one good
    wr(A_CT, 32'h23);
    u_peer.send(8'h81, 1'b0, 1'b1);
    rdc(A_ST, 32'hC4, "two_stop");
    rdc(A_RX, 32'h81, "two_stop_data");
    rdc(A_CT, 32'h23, "ctrl_back");
    // parity: even then odd
    for (int i = 0; i < 2; i++) begin
      wr(A_CT, (i == 0) ? 32'h0B : 32'h1B);
      p = (^8'h07) ^ i[0];
      u_peer.send(8'h07, p, 1'b1);
      rdc(A_RX, 32'h07, "parity_good");
      u_peer.send(8'h0B, ~p, 1'b1);
      rdc(A_ST, 32'h8C, "parity_set");
      rdc(A_RX, 32'h0B, "parity_data");
      u_peer.send(8'h07, p, 1'b1);
      rdc(A_RX, 32'h0B, "parity_halt");
      wr(A_ST, 32'hF7);
      rdc(A_ST, 32'h84, "parity_clear");
    end
    // transmit side
    wr(A_CT, 32'h03);
    wr(A_TX, 32'hA5);
    rdc(A_ST, 32'h00, "tx_write");
    rdc(A_TX, 32'hA5, "tx_back");
    @(negedge clk_i);
    chk("tx_data", 32'hA5, {24'h0, tx_data_o});
    chk("tx_empty_lo", 32'h0, {31'h0, tx_empty_o});
    chk("ctrl_pins", 32'h03, {26'h0, ctrl_o});
    @(posedge clk_i);
    u_peer.shift(1'b0, 1'b1);
    rdc(A_ST, 32'h00, "last_not_empty");
    u_peer.shift(1'b1, 1'b0);
    rdc(A_ST, 32'h80, "load_empty");
    @(negedge clk_i);
    chk("tx_empty_hi", 32'h1, {31'h0, tx_empty_o});
    @(posedge clk_i);
    u_peer.shift(1'b0, 1'b1);
    rdc(A_ST, 32'h84, "tx_end");
    wr(A_ST, 32'hFB);
    rdc(A_ST, 32'h84, "end_readonly");
    wr(A_ST, 32'h7F);
    rdc(A_ST, 32'h00, "empty_zero");
    wr(A_CT, 32'h01);
    rdc(A_ST, 32'h84, "tx_off");
    wrap_up();
  end
endmodule
`default_nettype wire
